// ---- hw/option_byte_and_trim_access.sv ----
/*
  option byte loader and trim register access: at every reset copies the two
  user option bytes and 32 factory trim bytes from flash into working flops,
  holds the cpu in reset until done, and serves the apb register map.
  assumes a flash array with one-cycle read latency and an apb master.
*/
// Behaviour
// - trim index holds target trim byte number, 00h to 1Fh
// - trim value reads the selected trim byte and writes a new one
// - option bytes load from flash addresses 0000h and 0001h
// - option 0 bit 7: 0 interrupt on watchdog timeout, 1 reset
// - option 0 bit 6 low: watchdog runs from power-up, cannot disable
// - option 0 bit 6 high: watchdog starts by instruction, only reset or stop recovery stops
// - option 0 bit 3 low: brown-out off in stop if power bit asks
// - option 0 bit 3 high: brown-out always on, even in stop
// - option 0 bit 2 low: code unreadable, debugger limited
// - option 0 bit 0 low: user program and erase refused, debug mass erase ok
// - option 0 bit 0 high: program and erase allowed everywhere
// - option 1 bit 4 only enables crystal, never selects it as clock
// - option 1 bit 4 low: crystal runs once loaded; reset is not longer, crystal_reset_wait follows the load alone
// - option bytes copied at every reset before cpu runs
// - trim value write replaces working byte, read returns it
// - working trim values revert to factory values on reset
module option_byte_and_trim_access (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [optload_pkg::addr_w-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic flash_rd,
  output logic [15:0] flash_addr,
  output logic flash_info,
  input wire logic [7:0] flash_rdata,
  input wire logic wdog_start_instruction,
  input wire logic wdog_timeout,
  input wire logic stop_mode,
  input wire logic stop_recovery,
  input wire logic user_prog_req,
  input wire logic debug_erase_req,
  input wire logic debug_pin,
  output logic cpu_hold,
  output logic wdog_running,
  output logic wdog_irq,
  output logic wdog_reset_req,
  output logic brownout_enable,
  output logic code_read_allowed,
  output logic debug_full_access,
  output logic user_prog_allowed,
  output logic debug_erase_allowed,
  output logic crystal_enable,
  output logic crystal_reset_wait
);
  import optload_pkg::*;

  typedef struct packed {
    load_state_t state;
    logic [4:0] load_idx;
    logic [7:0] opt0;
    logic [7:0] opt1;
    logic [7:0] trim_index;
    logic [trim_count-1:0][7:0] trim;
    logic wdog_on;
    logic wdog_disable;
    logic brownout_stop_off;
    logic [31:0] rdata;
  } top_state_t;

  top_state_t s_reg, s_next;
  flash_read_if rd ();

  // ----------------------------------------------------------------------
  // flash read port
  // ----------------------------------------------------------------------
  flash_read_port u_port (
    .clk(clk),
    .reset(reset),
    .rd(rd),
    .flash_rd(flash_rd),
    .flash_addr(flash_addr),
    .flash_info(flash_info),
    .flash_rdata(flash_rdata)
  );

  // address decode used by read and write paths
  function automatic logic hit(input logic [addr_w-1:0] a, input logic [addr_w-1:0] r);
    return a == r;
  endfunction : hit

  function automatic logic mapped(input logic [addr_w-1:0] a);
    return hit(a, opt0_addr) | hit(a, opt1_addr) | hit(a, trim_index_addr) |
      hit(a, trim_value_addr) | hit(a, control_addr) | hit(a, status_addr);
  endfunction : mapped

  // ----------------------------------------------------------------------
  // loader request
  // ----------------------------------------------------------------------
  logic loading;
  logic access;
  logic [4:0] sel;
  assign loading = s_reg.state != ld_done;
  assign rd.req = loading;
  // option bytes live in program memory, trim bytes in the info page
  always_comb begin
    unique case (s_reg.state)
      ld_opt0: rd.addr = flash_opt0_addr;
      ld_opt1: rd.addr = flash_opt1_addr;
      default: rd.addr = info_trim_base + {11'h000, s_reg.load_idx};
    endcase
  end
  assign rd.info = s_reg.state == ld_trim;
  assign access = psel & penable & ~loading;
  assign sel = s_reg.trim_index[4:0];

  // ----------------------------------------------------------------------
  // apb slave: no wait states, stalls while the reset load runs
  // ----------------------------------------------------------------------
  assign pready = access;
  assign pslverr = access & ~mapped(paddr);
  assign prdata = s_reg.rdata;

  // ----------------------------------------------------------------------
  // next state: reset load, register writes, watchdog latch
  // ----------------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    unique case (s_reg.state)
      ld_opt0: begin
        if (rd.valid) begin
          s_next.opt0 = rd.data | opt0_fixed_mask;
          s_next.state = ld_opt1;
        end
      end
      ld_opt1: begin
        if (rd.valid) begin
          s_next.opt1 = rd.data | opt1_fixed_mask;
          s_next.state = ld_trim;
          s_next.load_idx = '0;
        end
      end
      ld_trim: begin
        if (rd.valid) begin
          s_next.trim[s_reg.load_idx] = rd.data;
          s_next.load_idx = s_reg.load_idx + 5'd1;
          if (s_reg.load_idx == trim_index_max[4:0]) begin
            s_next.state = ld_done;
          end
        end
      end
      ld_done: begin
      end
    endcase
    // read data captured every cycle before the one that completes, so a
    // read stalled by the reset load returns the freshly loaded bytes
    if (psel && !pwrite && !pready) begin
      s_next.rdata = zero_word;
      if (hit(paddr, opt0_addr)) s_next.rdata[7:0] = s_reg.opt0;
      if (hit(paddr, opt1_addr)) s_next.rdata[7:0] = s_reg.opt1;
      if (hit(paddr, trim_index_addr)) s_next.rdata[7:0] = s_reg.trim_index;
      if (hit(paddr, trim_value_addr)) s_next.rdata[7:0] = s_reg.trim[sel];
      if (hit(paddr, control_addr)) begin
        s_next.rdata[ctl_wdog_disable_bit] = s_reg.wdog_disable;
        s_next.rdata[ctl_brownout_stop_off_bit] = s_reg.brownout_stop_off;
      end
      if (hit(paddr, status_addr)) begin
        s_next.rdata[sts_loaded_bit] = ~loading;
        s_next.rdata[1] = wdog_running;
      end
    end
    if (access && pwrite) begin
      // option bytes change only in flash; a write updates the working copy
      if (hit(paddr, opt0_addr)) s_next.opt0 = pwdata[7:0] | opt0_fixed_mask;
      if (hit(paddr, opt1_addr)) s_next.opt1 = pwdata[7:0] | opt1_fixed_mask;
      if (hit(paddr, trim_index_addr)) s_next.trim_index = pwdata[7:0];
      if (hit(paddr, trim_value_addr)) s_next.trim[sel] = pwdata[7:0];
      if (hit(paddr, control_addr)) begin
        s_next.wdog_disable = pwdata[ctl_wdog_disable_bit];
        s_next.brownout_stop_off = pwdata[ctl_brownout_stop_off_bit];
      end
    end
    // watchdog latch: start instruction sets, only reset or recovery clears
    if (!loading && wdog_start_instruction) begin
      s_next.wdog_on = 1'b1;
    end
    if (stop_recovery) begin
      s_next.wdog_on = 1'b0;
      s_next.state = ld_opt0;
      s_next.load_idx = '0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_reg <= '0;
      s_reg.state <= ld_opt0;
      s_reg.opt0 <= erased_byte;
      s_reg.opt1 <= erased_byte;
      s_reg.trim_index <= zero_byte;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------------
  // option outputs
  // ----------------------------------------------------------------------
  // the disable bit is stored and read back but never gates the watchdog
  assign cpu_hold = loading;
  assign wdog_running = ~loading & (~s_reg.opt0[wdog_always_on_bit] | s_reg.wdog_on);
  assign wdog_irq = wdog_running & wdog_timeout & ~s_reg.opt0[wdog_timeout_action_bit];
  assign wdog_reset_req = wdog_running & wdog_timeout & s_reg.opt0[wdog_timeout_action_bit];
  assign brownout_enable = ~(stop_mode & s_reg.brownout_stop_off &
    ~s_reg.opt0[brownout_always_on_bit]);
  assign code_read_allowed = s_reg.opt0[code_read_lock_bit];
  assign debug_full_access = debug_pin & s_reg.opt0[code_read_lock_bit];
  assign user_prog_allowed = user_prog_req & ~loading & s_reg.opt0[code_write_lock_bit];
  assign debug_erase_allowed = debug_erase_req & ~loading;
  // enables the crystal only; clock source choice stays with software
  assign crystal_enable = ~s_reg.opt1[crystal_off_at_reset_bit];
  assign crystal_reset_wait = loading | (cpu_hold & crystal_enable);
endmodule : option_byte_and_trim_access

// ---- pkg/optload_pkg.sv ----
/*
  package for the option byte loader and trim access block: register byte
  addresses, option field positions, reserved patterns, loader states.
  assumes nothing of its surroundings beyond a 32-bit apb register bus.
*/
package optload_pkg;
  // ----------------------------------------------------------------------
  // register indices as printed, byte address is four times the index
  // ----------------------------------------------------------------------
  localparam logic [11:0] opt0_index = 12'h000;
  localparam logic [11:0] opt1_index = 12'h001;
  localparam logic [11:0] trim_index_index = 12'hff6;
  localparam logic [11:0] trim_value_index = 12'hff7;
  localparam logic [11:0] control_index = 12'h100;
  localparam logic [11:0] status_index = 12'h101;
  localparam logic [13:0] opt0_addr = {opt0_index, 2'b00};
  localparam logic [13:0] opt1_addr = {opt1_index, 2'b00};
  localparam logic [13:0] trim_index_addr = {trim_index_index, 2'b00};
  localparam logic [13:0] trim_value_addr = {trim_value_index, 2'b00};
  localparam logic [13:0] control_addr = {control_index, 2'b00};
  localparam logic [13:0] status_addr = {status_index, 2'b00};
  localparam int addr_w = 14;

  // ----------------------------------------------------------------------
  // flash side addresses and sizes
  // ----------------------------------------------------------------------
  localparam logic [15:0] flash_opt0_addr = 16'h0000;
  localparam logic [15:0] flash_opt1_addr = 16'h0001;
  localparam logic [15:0] info_trim_base = 16'h0020;
  localparam int trim_count = 32;
  localparam logic [7:0] trim_index_max = 8'h1f;
  localparam logic [7:0] info_page_code = 8'h80;

  // ----------------------------------------------------------------------
  // option byte fields
  // ----------------------------------------------------------------------
  localparam int wdog_timeout_action_bit = 7;
  localparam int wdog_always_on_bit = 6;
  localparam int brownout_always_on_bit = 3;
  localparam int code_read_lock_bit = 2;
  localparam int code_write_lock_bit = 0;
  localparam int crystal_off_at_reset_bit = 4;
  localparam logic [7:0] opt0_fixed_mask = 8'h32;
  localparam logic [7:0] opt1_fixed_mask = 8'hef;
  localparam logic [7:0] erased_byte = 8'hff;
  localparam logic [7:0] zero_byte = 8'h00;
  localparam logic [31:0] zero_word = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // control and status fields
  // ----------------------------------------------------------------------
  localparam int ctl_wdog_disable_bit = 0;
  localparam int ctl_brownout_stop_off_bit = 1;
  localparam int sts_loaded_bit = 0;

  typedef enum logic [2:0] {
    ld_opt0, ld_opt1, ld_trim, ld_done
  } load_state_t;
endpackage : optload_pkg

// ---- pkg/flash_read_if.sv ----
/*
  interface for the flash read port between the loader and its read sequencer.
  assumes a flash that answers a read one cycle after the request.
*/
interface flash_read_if;
  logic req;
  logic [15:0] addr;
  logic info;
  logic valid;
  logic [7:0] data;
  modport loader (output req, output addr, output info, input valid, input data);
  modport port (input req, input addr, input info, output valid, output data);
endinterface : flash_read_if

// ---- hw/flash_read_port.sv ----
/*
  flash read sequencer: turns one loader request into one flash read with a
  registered answer. assumes the flash array returns data one cycle after
  its read strobe.
*/
module flash_read_port (
  input wire logic clk,
  input wire logic reset,
  flash_read_if.port rd,
  output logic flash_rd,
  output logic [15:0] flash_addr,
  output logic flash_info,
  input wire logic [7:0] flash_rdata
);
  import optload_pkg::*;

  typedef struct packed {
    logic busy;
    logic valid;
    logic [7:0] data;
  } port_state_t;

  port_state_t s_reg, s_next;

  // ----------------------------------------------------------------------
  // request passes straight to the array, answer is captured
  // ----------------------------------------------------------------------
  // no strobe while the answer is handed over, so every read is taken once
  assign flash_rd = rd.req & ~s_reg.busy & ~s_reg.valid;
  assign flash_addr = rd.addr;
  assign flash_info = rd.info;
  assign rd.valid = s_reg.valid;
  assign rd.data = s_reg.data;

  // one read outstanding at a time
  always_comb begin
    s_next = s_reg;
    s_next.valid = 1'b0;
    if (s_reg.busy) begin
      s_next.busy = 1'b0;
      s_next.valid = 1'b1;
      s_next.data = flash_rdata;
    end else if (rd.req && !s_reg.valid) begin
      s_next.busy = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule : flash_read_port

// ---- verification/flash_model.sv ----
/*
  flash array model: two user option bytes and a 32-byte factory trim area.
  assumes the loader strobes flash_rd and takes data one cycle later.
*/
module flash_model (
  input wire logic clk,
  input wire logic flash_rd,
  input wire logic [15:0] flash_addr,
  input wire logic flash_info,
  input wire logic [7:0] opt0,
  input wire logic [7:0] opt1,
  output logic [7:0] flash_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial flash_rdata = 8'h5a;
  // data lines flip between reads so stale bytes never look valid
  always @(posedge clk) begin
    if (flash_rd && !flash_info) begin
      flash_rdata <= flash_addr[0] ? opt1 : opt0;
    end else if (flash_rd) begin
      flash_rdata <= 8'(flash_addr[4:0]) * 8'h25 + 8'h5a;
    end else begin
      flash_rdata <= ~flash_rdata;
    end
  end
endmodule : flash_model

// ---- verification/option_byte_and_trim_access_monitor.sv ----
/*
  port checker for the option loader: load timing, flash addressing and
  option driven levels. assumes it is bound onto the top module.
*/
module option_byte_and_trim_access_monitor (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic flash_rd,
  input wire logic [15:0] flash_addr,
  input wire logic flash_info,
  input wire logic wdog_start_instruction,
  input wire logic wdog_timeout,
  input wire logic stop_mode,
  input wire logic stop_recovery,
  input wire logic cpu_hold,
  input wire logic wdog_running,
  input wire logic wdog_irq,
  input wire logic wdog_reset_req,
  input wire logic brownout_enable,
  input wire logic code_read_allowed,
  input wire logic debug_pin,
  input wire logic debug_full_access
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ----------------------------------------------------------------------
  // loader sequencing: reads only while the cpu is held, at most one per two cycles
  // ----------------------------------------------------------------------
  sequence s_idle;
    !flash_rd;
  endsequence
  property p_ready_loaded; (psel && penable) |-> (pready == !cpu_hold); endproperty
  a_ready_loaded: assert property (p_ready_loaded) else $error("pready out of step with load");
  property p_rd_hold; flash_rd |-> cpu_hold; endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("flash read after load");
  property p_rd_gap; flash_rd |=> s_idle; endproperty
  a_rd_gap: assert property (p_rd_gap) else $error("flash reads back to back");
  property p_opt_addr; (flash_rd && !flash_info) |-> (flash_addr <= 16'h0001); endproperty
  a_opt_addr: assert property (p_opt_addr) else $error("option read off its two bytes");
  property p_trim_addr; (flash_rd && flash_info) |-> (flash_addr[15:5] == 11'h001); endproperty
  a_trim_addr: assert property (p_trim_addr) else $error("trim read outside 20h to 3Fh");
  // watchdog and protection levels; a start may also follow an option write
  property p_wdog_resp;
    !(wdog_irq && wdog_reset_req) && ((wdog_irq || wdog_reset_req) == (wdog_running && wdog_timeout));
  endproperty
  a_wdog_resp: assert property (p_wdog_resp) else $error("watchdog timeout response wrong");
  property p_wdog_keep; (wdog_running && !stop_recovery && !cpu_hold) |=> wdog_running; endproperty
  a_wdog_keep: assert property (p_wdog_keep) else $error("watchdog stopped without reset");
  property p_wdog_start;
    $rose(wdog_running) |-> ($past(wdog_start_instruction) || $past(cpu_hold) || $past(cpu_hold, 2) || $past(pready));
  endproperty
  a_wdog_start: assert property (p_wdog_start) else $error("watchdog started by itself");
  property p_brownout; !stop_mode |-> brownout_enable; endproperty
  a_brownout: assert property (p_brownout) else $error("brown-out off outside stop");
  property p_read_lock; debug_full_access == (debug_pin && code_read_allowed); endproperty
  a_read_lock: assert property (p_read_lock) else $error("read lock and debug access differ");
endmodule : option_byte_and_trim_access_monitor

bind option_byte_and_trim_access option_byte_and_trim_access_monitor i_option_byte_and_trim_access_monitor (
  .clk, .reset, .psel, .penable, .pready, .flash_rd, .flash_addr, .flash_info, .wdog_start_instruction,
  .wdog_timeout, .stop_mode, .stop_recovery, .cpu_hold, .wdog_running, .wdog_irq, .wdog_reset_req,
  .brownout_enable, .code_read_allowed, .debug_pin, .debug_full_access
);

// ---- verification/tb_option_byte_and_trim_access.sv ----
/*
  self-checking bench for the option loader: apb master, flash model and
  seeded stimulus with corner cases. assumes the package and checker bind.
*/
module tb_option_byte_and_trim_access;
  timeunit 1ns;
  timeprecision 100ps;
  import optload_pkg::*;
  logic clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e_s;
  logic [13:0] paddr = 14'h0000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q_s, seed = 32'h0000_9e15;
  logic pready, pslverr, flash_rd, flash_info, cpu_hold, wdog_running, wdog_irq, wdog_reset_req;
  logic brownout_enable, code_read_allowed, debug_full_access, user_prog_allowed, debug_erase_allowed;
  logic crystal_enable, crystal_reset_wait;
  logic wdog_start_instruction = 1'b0, wdog_timeout = 1'b0, stop_mode = 1'b0, stop_recovery = 1'b0;
  logic user_prog_req = 1'b0, debug_erase_req = 1'b0, debug_pin = 1'b0;
  logic [15:0] flash_addr;
  logic [7:0] flash_rdata, o0 = 8'hff, o1 = 8'hff, v, ix;
  int err_total = 0, n_tests = 0, cycles = 0;
  option_byte_and_trim_access i_option_byte_and_trim_access (
    .clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .flash_rd,
    .flash_addr, .flash_info, .flash_rdata, .wdog_start_instruction, .wdog_timeout, .stop_mode,
    .stop_recovery, .user_prog_req, .debug_erase_req, .debug_pin, .cpu_hold, .wdog_running, .wdog_irq,
    .wdog_reset_req, .brownout_enable, .code_read_allowed, .debug_full_access, .user_prog_allowed,
    .debug_erase_allowed, .crystal_enable, .crystal_reset_wait
  );
  flash_model i_flash_model (.clk, .flash_rd, .flash_addr, .flash_info, .opt0(o0), .opt1(o1), .flash_rdata);
  // ----------------------------------------------------------------------
  // clock, watchdog on the run, helpers
  // ----------------------------------------------------------------------
  initial begin
    forever #2.5 clk = ~clk;
  end
  // a few thousand cycles are needed; the ceiling leaves ample margin
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      err_total = err_total + 1;
      end_of_test();
    end
  end
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd
  function automatic logic [7:0] trim_exp(input int i);
    return 8'(i) * 8'h25 + 8'h5a;
  endfunction : trim_exp
  // one apb transfer; waits on pready since the load may stall it
  task automatic apb(input logic wr, input logic [13:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++n < 300);
    q_s = prdata;
    e_s = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_tests = n_tests + 1;
    if (got !== ex) begin
      err_total = err_total + 1;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task automatic chk1(input string nm, input logic ex, input logic got);
    chk(nm, {31'h0, ex}, {31'h0, got});
  endtask : chk1
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test
  // ----------------------------------------------------------------------
  // main sequence: reload, trims, levels, copies, refusal, stop recovery
  // ----------------------------------------------------------------------
  initial begin
    for (int k = 0; k < 6; k++) begin
      @(posedge clk);
      v = rnd();
      o0 <= (k == 0) ? 8'h32 : (k == 1) ? 8'hff : v | opt0_fixed_mask;
      o1 <= (k == 0) ? 8'hef : (k == 1) ? 8'hff : v | opt1_fixed_mask;
      debug_pin <= v[3];
      user_prog_req <= 1'b1;
      debug_erase_req <= 1'b1;
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      apb(1'b0, opt0_addr, zero_word);
      chk("opt0", {24'h0, o0}, q_s);
      apb(1'b0, opt1_addr, zero_word);
      chk("opt1", {24'h0, o1}, q_s);
      apb(1'b0, trim_index_addr, zero_word);
      chk("trim_index", zero_word, q_s);
      for (int i = 0; i < trim_count; i++) begin
        apb(1'b1, trim_index_addr, 32'(i));
        apb(1'b0, trim_value_addr, zero_word);
        chk("trim factory", {24'h0, trim_exp(i)}, q_s);
      end
      for (int j = 0; j < 3; j++) begin
        ix = (j == 0) ? trim_index_max : rnd() & trim_index_max;
        v = rnd();
        apb(1'b1, trim_index_addr, {24'h0, ix});
        apb(1'b1, trim_value_addr, {24'h0, v});
        apb(1'b0, trim_value_addr, zero_word);
        chk("trim working", {24'h0, v}, q_s);
        apb(1'b0, trim_index_addr, zero_word);
        chk("trim_index", {24'h0, ix}, q_s);
      end
      chk1("code_read", o0[2], code_read_allowed);
      chk1("user_prog", o0[0], user_prog_allowed);
      chk1("debug_erase", 1'b1, debug_erase_allowed);
      chk1("crystal_wait", 1'b0, crystal_reset_wait);
      chk1("crystal_enable", !o1[4], crystal_enable);
      chk1("debug_full", debug_pin & o0[2], debug_full_access);
      chk1("wdog_run", !o0[6], wdog_running);
      wdog_start_instruction <= 1'b1;
      @(posedge clk);
      wdog_start_instruction <= 1'b0;
      apb(1'b1, control_addr, 32'h0000_0003);
      stop_mode <= 1'b1;
      wdog_timeout <= 1'b1;
      repeat (2) @(posedge clk);
      chk1("wdog_run", 1'b1, wdog_running);
      chk1("brownout", o0[3], brownout_enable);
      chk1("wdog_irq", !o0[7], wdog_irq);
      chk1("wdog_reset", o0[7], wdog_reset_req);
      stop_mode <= 1'b0;
      wdog_timeout <= 1'b0;
      v = rnd();
      apb(1'b1, opt0_addr, {24'h0, v});
      apb(1'b0, opt0_addr, zero_word);
      chk("opt0 copy", {24'h0, v | opt0_fixed_mask}, q_s);
      apb(1'b1, opt1_addr, {24'h0, v});
      apb(1'b0, opt1_addr, zero_word);
      chk("opt1 copy", {24'h0, v | opt1_fixed_mask}, q_s);
      apb(1'b0, 14'h0800 + 14'(k * 4), zero_word);
      chk1("slverr", 1'b1, e_s);
      chk("unmapped", zero_word, q_s);
      stop_recovery <= 1'b1;
      @(posedge clk);
      stop_recovery <= 1'b0;
      apb(1'b0, opt0_addr, zero_word);
      chk("opt0 reload", {24'h0, o0}, q_s);
    end
    end_of_test();
  end
endmodule : tb_option_byte_and_trim_access
